// [src/eidet_pkg.sv]
package eidet_pkg;
	localparam int NPIN = 16;
	localparam int NCH = 17;
	localparam int NPHYS = 32;
	localparam int FILT_SAMPLES = 3;

	localparam logic [11:0] OFF_PIN_CTRL = 12'h000;
	localparam logic [11:0] OFF_PIN_STAT = 12'h040;
	localparam logic [11:0] OFF_NMI_CTRL = 12'h080;
	localparam logic [11:0] OFF_NMI_STAT = 12'h084;
	localparam logic [11:0] OFF_FAST = 12'h088;
	localparam logic [11:0] OFF_ISTAT = 12'h08c;
	localparam logic [11:0] OFF_IMASK = 12'h090;

	localparam int CTL_EN = 0;
	localparam int CTL_COND = 1;
	localparam int CTL_DET_LO = 2;
	localparam int CTL_FSEL_LO = 4;
	localparam int CTL_CLR = 7;
	localparam int CTL_PSEL_LO = 8;

	localparam int NS_FLAG = 0;
	localparam int NS_SRC_LO = 3;
	localparam int NSRC = 5;

	localparam logic [4:0] FAST_NONE = 5'h10;
	localparam logic [5:0] DIV8_LAST = 6'h07;
	localparam logic [5:0] DIV32_LAST = 6'h1f;
	localparam logic [5:0] DIV64_LAST = 6'h3f;
	localparam logic LVL_IDLE = 1'b1;

	typedef enum logic [1:0] {
		DET_LOW  = 2'b00,
		DET_FALL = 2'b01,
		DET_RISE = 2'b10,
		DET_BOTH = 2'b11
	} eidet_det_e;

	typedef enum logic [2:0] {
		FLT_OFF   = 3'h0,
		FLT_DIV1  = 3'h1,
		FLT_DIV8  = 3'h2,
		FLT_DIV32 = 3'h3,
		FLT_DIV64 = 3'h4
	} eidet_flt_e;
endpackage

// [src/eidet_filt_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface eidet_filt_if;
	logic raw;
	logic on;
	logic tick;
	logic level;
	modport core (output raw, output on, output tick, input level);
	modport flt (input raw, input on, input tick, output level);
endinterface
`default_nettype wire

// [src/eidet_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module eidet_filter
	import eidet_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic  presetn,
	eidet_filt_if.flt  f
);
	logic       cand_q;
	logic       stable_q;
	logic [1:0] run_q;

	// A level is accepted after the same value is seen on consecutive ticks.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cand_q <= LVL_IDLE;
			stable_q <= LVL_IDLE;
			run_q <= 2'h0;
		end
		else if (!f.on)
		begin
			cand_q <= f.raw;
			stable_q <= f.raw;
			run_q <= 2'h0;
		end
		else if (f.tick)
		begin
			if (f.raw != cand_q)
			begin
				cand_q <= f.raw;
				run_q <= 2'h0;
			end
			else if (run_q == 2'(FILT_SAMPLES - 2))
				stable_q <= cand_q;
			else
				run_q <= run_q + 2'h1;
		end
	end

	assign f.level = f.on ? stable_q : f.raw;
endmodule // eidet_filter
`default_nettype wire

// [src/eidet_top.sv]
`timescale 1ns/1ps
`default_nettype none
module eidet_top
	import eidet_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic [11:0]              paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [eidet_pkg::NPHYS-1:0] phys_pin,
	input  wire logic                     nmi_pin,
	input  wire logic [eidet_pkg::NSRC-1:0] nmi_src_evt,
	output logic [eidet_pkg::NPIN-1:0]    request_flag,
	output logic                          fast_request,
	output logic                          nmi_request,
	output logic                          irq
);
	import eidet_pkg::*;

	logic             en_q [NPIN];
	logic [1:0]       mode_q [NPIN];
	logic [4:0]       route_q [NPIN];
	logic [2:0]       fsel_q [NCH];
	logic             nmi_en_q;
	logic             nmi_cond_q;
	logic [NSRC-1:0]  src_q;
	logic [4:0]       fast_q;
	logic [NCH-1:0]   istat_q;
	logic [NCH-1:0]   imask_q;
	logic [NCH-1:0]   flag_q;
	logic [NCH-1:0]   det_q;
	logic [NCH-1:0]   prev_q;
	logic [NCH-1:0]   lvl;
	logic [NCH-1:0]   en_all;
	logic [1:0]       mode_all [NCH];
	logic [NCH-1:0]   clr;
	logic [NCH-1:0]   ev;
	logic [5:0]       div_q;
	logic [31:0]      prdata_q;
	logic             err_q;
	logic [31:0]      rd_d;
	logic             err_d;
	logic             wr;
	logic [3:0]       widx;

	function automatic logic pin_hit(input logic [11:0] a, input logic [11:0] base);
		return (a[11:6] == base[11:6]) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic tick_of(input logic [2:0] fs, input logic [5:0] c);
		logic t;
		t = 1'b0;
		case (fs)
			FLT_DIV1:  t = 1'b1;
			FLT_DIV8:  t = (c[2:0] == DIV8_LAST[2:0]);
			FLT_DIV32: t = (c[4:0] == DIV32_LAST[4:0]);
			FLT_DIV64: t = (c == DIV64_LAST);
			default:   t = 1'b0;
		endcase
		return t;
	endfunction

	function automatic logic detect(input logic [1:0] m, input logic p, input logic c);
		logic d;
		d = 1'b0;
		case (m)
			DET_LOW:  d = !c;
			DET_FALL: d = p && !c;
			DET_RISE: d = !p && c;
			default:  d = p != c;
		endcase
		return d;
	endfunction

	assign wr = psel && penable && pwrite;
	assign widx = paddr[5:2];

	// Secondary peripheral clock divider.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 6'h00;
		else
			div_q <= div_q + 6'h01;
	end

	// Per-channel filters; pins are routed from the pads first.
	generate
		for (genvar g = 0; g < NCH; g++)
		begin : g_ch
			eidet_filt_if fif ();
			if (g < NPIN)
			begin : g_pin
				assign fif.raw = phys_pin[route_q[g]];
				assign en_all[g] = en_q[g];
				assign mode_all[g] = mode_q[g];
			end
			else
			begin : g_nmi
				assign fif.raw = nmi_pin;
				assign en_all[g] = nmi_en_q;
				assign mode_all[g] = {nmi_cond_q, !nmi_cond_q};
			end
			assign fif.on = (fsel_q[g] != FLT_OFF);
			assign fif.tick = tick_of(fsel_q[g], div_q);
			assign lvl[g] = fif.level;
			eidet_filter u_flt (
				.pclk    (pclk),
				.presetn (presetn),
				.f       (fif.flt)
			);
		end
	endgenerate

	// Configuration registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NPIN; i++)
			begin
				en_q[i] <= 1'b0;
				mode_q[i] <= DET_LOW;
				route_q[i] <= 5'h00;
			end
			for (int i = 0; i < NCH; i++)
				fsel_q[i] <= FLT_OFF;
			nmi_cond_q <= 1'b0;
			fast_q <= FAST_NONE;
			imask_q <= '0;
		end
		else if (wr)
		begin
			if (pin_hit(paddr, OFF_PIN_CTRL))
			begin
				en_q[widx] <= pwdata[CTL_EN];
				mode_q[widx] <= pwdata[CTL_DET_LO +: 2];
				fsel_q[widx] <= pwdata[CTL_FSEL_LO +: 3];
				route_q[widx] <= pwdata[CTL_PSEL_LO +: 5];
			end
			else if (paddr == OFF_NMI_CTRL)
			begin
				nmi_cond_q <= pwdata[CTL_COND];
				fsel_q[NPIN] <= pwdata[CTL_FSEL_LO +: 3];
			end
			else if (paddr == OFF_FAST)
				fast_q <= pwdata[4:0];
			else if (paddr == OFF_IMASK)
				imask_q <= pwdata[NCH-1:0];
		end
	end

	// The non-maskable enable can only be set.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nmi_en_q <= 1'b0;
		else if (wr && (paddr == OFF_NMI_CTRL) && pwdata[CTL_EN])
			nmi_en_q <= 1'b1;
	end

	// Event detection on filtered levels.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_q <= {NCH{LVL_IDLE}};
			det_q <= '0;
		end
		else
		begin
			prev_q <= lvl;
			for (int i = 0; i < NCH; i++)
				det_q[i] <= en_all[i] && detect(mode_all[i], prev_q[i], lvl[i]);
		end
	end

	// Clear commands: explicit clear or disable on pins, clear or W1C on NMI.
	always_comb
	begin
		clr = '0;
		for (int i = 0; i < NPIN; i++)
			clr[i] = wr && pin_hit(paddr, OFF_PIN_CTRL) && (widx == 4'(i)) &&
				(pwdata[CTL_CLR] || !pwdata[CTL_EN]);
		clr[NPIN] = wr && (((paddr == OFF_NMI_CTRL) && pwdata[CTL_CLR]) ||
			((paddr == OFF_NMI_STAT) && pwdata[NS_FLAG]));
	end

	// A detection already in flight wins over the clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= '0;
		else
			flag_q <= det_q | (flag_q & ~clr);
	end

	// Non-maskable source flags.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			src_q <= '0;
		else if (wr && (paddr == OFF_NMI_STAT))
			src_q <= nmi_src_evt | (src_q & ~pwdata[NS_SRC_LO +: NSRC]);
		else
			src_q <= nmi_src_evt | src_q;
	end

	// Sticky event status, write one to clear; new events win.
	assign ev = {det_q[NPIN] || (nmi_src_evt != '0), det_q[NPIN-1:0]};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			istat_q <= '0;
		else if (wr && (paddr == OFF_ISTAT))
			istat_q <= ev | (istat_q & ~pwdata[NCH-1:0]);
		else
			istat_q <= ev | istat_q;
	end

	assign irq = |(istat_q & imask_q);

	// Requests to the processor; the fast source leaves the normal path.
	always_comb
	begin
		request_flag = '0;
		for (int i = 0; i < NPIN; i++)
			request_flag[i] = flag_q[i] && (fast_q != 5'(i));
	end

	assign fast_request = !fast_q[4] && flag_q[fast_q[3:0]];
	assign nmi_request = flag_q[NPIN] || (src_q != '0);

	// Read decode, captured in the setup phase.
	always_comb
	begin
		rd_d = 32'h0;
		err_d = 1'b0;
		if (pin_hit(paddr, OFF_PIN_CTRL))
			rd_d = {19'h0, route_q[widx], 1'b0, fsel_q[widx], mode_q[widx], 1'b0, en_q[widx]};
		else if (pin_hit(paddr, OFF_PIN_STAT))
			rd_d = {28'h0, mode_q[widx], lvl[widx], flag_q[widx]};
		else if (paddr == OFF_NMI_CTRL)
			rd_d = {24'h0, 1'b0, fsel_q[NPIN], 2'h0, nmi_cond_q, nmi_en_q};
		else if (paddr == OFF_NMI_STAT)
			rd_d = {24'h0, src_q, lvl[NPIN], nmi_cond_q, flag_q[NPIN]};
		else if (paddr == OFF_FAST)
			rd_d = {27'h0, fast_q};
		else if (paddr == OFF_ISTAT)
			rd_d = {15'h0, istat_q};
		else if (paddr == OFF_IMASK)
			rd_d = {15'h0, imask_q};
		else
			err_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0;
			err_q <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_q <= pwrite ? 32'h0 : rd_d;
			err_q <= err_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_rise2;
		en_q[2] && (mode_q[2] == DET_RISE) && !prev_q[2] && lvl[2] ##1 det_q[2];
	endsequence

	sequence s_late_disable0;
		det_q[0] && clr[0];
	endsequence

	a_nmi_en_sticky: assert property ($past(nmi_en_q) |-> nmi_en_q)
		else $error("non-maskable enable dropped");

	a_rise_to_flag: assert property (s_rise2 |=> flag_q[2] && request_flag[2] == (fast_q != 5'h2))
		else $error("rising edge did not raise the flag");

	a_disable_clears: assert property (clr[2] && !det_q[2] |=> !flag_q[2])
		else $error("flag survived disable or clear");

	a_late_event: assert property (s_late_disable0 |=> flag_q[0])
		else $error("in-flight event lost on disable");

	a_disabled_quiet: assert property (!en_q[1] |=> !det_q[1])
		else $error("disabled pin detected an event");

	a_fast_excl: assert property (!fast_q[4] |-> !request_flag[fast_q[3:0]] &&
		fast_request == flag_q[fast_q[3:0]])
		else $error("fast source also on normal path");

	a_src_sticky: assert property (nmi_src_evt[0] |=> src_q[0] && nmi_request)
		else $error("source event not latched");

	a_stat_layout: assert property (psel && !penable && !pwrite && pin_hit(paddr, OFF_PIN_STAT)
		|=> prdata[7:4] == 4'h0 && prdata[0] == $past(flag_q[widx]))
		else $error("pin status layout wrong");

	a_filt_tick: assert property ((fsel_q[5] == FLT_DIV8) && $stable(fsel_q[5]) &&
		$changed(lvl[5]) |-> ($past(div_q) & DIV8_LAST) == DIV8_LAST)
		else $error("filtered level moved off a sample tick");

	a_low_level: assert property (en_q[0] && (mode_q[0] == DET_LOW) && !lvl[0]
		##1 en_q[0] |=> flag_q[0])
		else $error("low level did not set the flag");
endmodule // eidet_top
`default_nettype wire

// [tb/eidet_pad_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eidet_pad_model
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [eidet_pkg::NPHYS-1:0] pad_set,
	input  wire logic                        nmi_set,
	input  wire logic [eidet_pkg::NSRC-1:0]  src_set,
	output logic      [eidet_pkg::NPHYS-1:0] phys_pin,
	output logic                             nmi_pin,
	output logic      [eidet_pkg::NSRC-1:0]  nmi_src_evt
);
	import eidet_pkg::*;
	// Pads and event sources change only just after a clock edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phys_pin    <= '1;
			nmi_pin     <= 1'b1;
			nmi_src_evt <= '0;
		end
		else
		begin
			phys_pin    <= pad_set;
			nmi_pin     <= nmi_set;
			nmi_src_evt <= src_set;
		end
	end
endmodule // eidet_pad_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import eidet_pkg::*;
	logic             pclk = 1'b0;
	logic             presetn = 1'b1;
	logic [11:0]      paddr = '0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [31:0]      pwdata = '0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [NPHYS-1:0] pad_set = '1;
	logic             nmi_set = 1'b1;
	logic [NSRC-1:0]  src_set = '0;
	logic [NPHYS-1:0] phys_pin;
	logic             nmi_pin;
	logic [NSRC-1:0]  nmi_src_evt;
	logic [NPIN-1:0]  request_flag;
	logic             fast_request;
	logic             nmi_request;
	logic             irq;
	logic [31:0]      rd;
	logic             err;
	int               n_mismatch = 0;
	int               n_compared = 0;
	int               cyc = 0;
	int               p;

	eidet_pad_model pads (.pclk(pclk), .presetn(presetn), .pad_set(pad_set), .nmi_set(nmi_set),
		.src_set(src_set), .phys_pin(phys_pin), .nmi_pin(nmi_pin), .nmi_src_evt(nmi_src_evt));
	eidet_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phys_pin(phys_pin), .nmi_pin(nmi_pin), .nmi_src_evt(nmi_src_evt),
		.request_flag(request_flag), .fast_request(fast_request), .nmi_request(nmi_request),
		.irq(irq));

	initial
	begin
		forever #4 pclk = ~pclk;
	end

	task automatic complete_run;
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc > 8000)
		begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", w, exp, seen);
		end
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input int a, input int d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= 12'(a);
		pwdata  <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input int a, input int d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string w, input int a, input int e);
		apb(1'b0, a, 0);
		chk(w, rd, 32'(e));
	endtask

	initial
	begin
		presetn = 1'b0;
		tk(2);
		presetn <= 1'b1;
		tk(1);
		rdc("stat0", OFF_PIN_STAT, 2);
		rdc("fast0", OFF_FAST, 32'h10);
		apb(1'b0, 32'hffc, 0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		wr(OFF_IMASK, 32'h1ffff);
		for (int m = 0; m < 4; m++)
		begin
			wr(OFF_PIN_CTRL + 4 * m, (m << 8) | (m << 2) | 1);
			rdc("cond", OFF_PIN_STAT + 4 * m, (m << 2) | 2);
			pad_set[m] <= 1'b0;
			tk(6);
			rdc("det a", OFF_PIN_STAT + 4 * m, (m << 2) | int'(m != 2));
			if (m != 0)
				wr(OFF_PIN_CTRL + 4 * m, (m << 8) | (m << 2) | 32'h81);
			pad_set[m] <= 1'b1;
			tk(6);
			rdc("det b", OFF_PIN_STAT + 4 * m, (m << 2) | 2 | int'(m != 1));
		end
		chk("irq on", irq, 1);
		wr(OFF_IMASK, 0);
		chk("irq masked", irq, 0);
		wr(OFF_ISTAT, 32'h1ffff);
		rdc("istat", OFF_ISTAT, 0);
		wr(OFF_IMASK, 32'h1ffff);
		chk("irq clr", irq, 0);
		wr(OFF_PIN_CTRL + 8, 32'h208);
		rdc("dis", OFF_PIN_STAT + 8, 32'ha);
		pad_set[2] <= 1'b0;
		tk(6);
		pad_set[2] <= 1'b1;
		tk(6);
		rdc("dis pin", OFF_PIN_STAT + 8, 32'ha);
		pad_set[0] <= 1'b0;
		tk(4);
		wr(OFF_PIN_CTRL, 0);
		rdc("late", OFF_PIN_STAT, 1);
		pad_set[0] <= 1'b1;
		wr(OFF_FAST, 3);
		chk("fast", {fast_request, request_flag}, 32'h10001);
		wr(OFF_FAST, 32'h10);
		wr(OFF_PIN_CTRL + 16, 32'h1405);
		pad_set[4] <= 1'b0;
		tk(6);
		rdc("route a", OFF_PIN_STAT + 16, 6);
		pad_set[20] <= 1'b0;
		tk(6);
		rdc("route b", OFF_PIN_STAT + 16, 5);
		for (int f = 1; f < 5; f++)
		begin
			p = (f == 1) ? 1 : (f == 2) ? 8 : (f == 3) ? 32 : 64;
			wr(OFF_PIN_CTRL + 20, 32'h505 | (f << 4));
			pad_set[5] <= 1'b0;
			tk(1);
			pad_set[5] <= 1'b1;
			tk(3 * p + 8);
			rdc("glitch", OFF_PIN_STAT + 20, 6);
			pad_set[5] <= 1'b0;
			tk(3 * p + 8);
			rdc("filtered", OFF_PIN_STAT + 20, 5);
			pad_set[5] <= 1'b1;
			tk(3 * p + 8);
			wr(OFF_PIN_CTRL + 20, 32'h585 | (f << 4));
		end
		wr(OFF_NMI_CTRL, 1);
		wr(OFF_NMI_CTRL, 0);
		apb(1'b0, OFF_NMI_CTRL, 0);
		chk("nmi en", rd[0], 1);
		nmi_set <= 1'b0;
		tk(6);
		chk("nmi req", nmi_request, 1);
		rdc("nmi flag", OFF_NMI_STAT, 1);
		nmi_set <= 1'b1;
		wr(OFF_NMI_STAT, 1);
		for (int s = 0; s < NSRC; s++)
		begin
			src_set[s] <= 1'b1;
			tk(1);
			src_set[s] <= 1'b0;
			tk(4);
			rdc("nmi src", OFF_NMI_STAT, 32'h4 | (32'h8 << s));
			wr(OFF_NMI_STAT, 32'h8 << s);
		end
		rdc("nmi clr", OFF_NMI_STAT, 4);
		wr(OFF_NMI_CTRL, 32'h3);
		nmi_set <= 1'b0;
		tk(6);
		rdc("nmi rise a", OFF_NMI_STAT, 2);
		nmi_set <= 1'b1;
		tk(6);
		rdc("nmi rise b", OFF_NMI_STAT, 7);
		chk("nmi req b", nmi_request, 1);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
